// ===== rtl/system_fault_status_word.v
// Register access over APB and the placing of the registers are this design's own decisions.
`include "fault_word_defs.vh"
module system_fault_status_word #(
	parameter [15:0] RAM_CAPACITY = 16'h4000,
	parameter [15:0] BUF_DEFAULT  = 16'h1000,
	parameter [15:0] CLK_WAIT     = `CLK_WAIT_CYCLES
) (
	input  wire        MCLK_I,
	input  wire        SYS_RST_I,
	input  wire        PSEL_I,
	input  wire        PENABLE_I,
	input  wire        PWRITE_I,
	input  wire [11:0] PADDR_I,
	input  wire [31:0] PWDATA_I,
	output wire        PREADY_O,
	output wire        PSLVERR_O,
	output wire [31:0] PRDATA_O,
	input  wire        SAVE_REQ_I,
	input  wire        PROGRAM_TOO_BIG_I,
	output reg         SAVE_GO_O,
	input  wire [15:0] BUF_REQ_SIZE_I,
	output reg  [15:0] BUF_SIZE_O,
	input  wire        GLOBAL_STOP_I,
	input  wire        PHASE_TICK_I,
	input  wire        SERVO_TICK_I,
	input  wire        SYSFILE_ERR_I,
	input  wire        SETTINGS_ERR_I,
	input  wire        PROJECT_ERR_I,
	input  wire        FACTORY_DEFAULT_I,
	input  wire        RT_WDT_EXPIRE_I,
	input  wire        BG_WDT_EXPIRE_I,
	input  wire        MOTOR_EN_REQ_I,
	output wire        MOTOR_EN_O,
	output wire [31:0] STATUS_O
);
	////////////////////////////////////////////////////////////////
	reg  [11:0] flag_reg;
	reg         start_reg;
	wire        ph_miss;
	wire        sv_miss;
	wire        ph_done;
	wire        ctl_wr;
	wire [31:0] ctl_data;
	// Reset command over the bus: a write of bit 0 to the control register
	wire        soft_rst = ctl_wr & ctl_data[0];
	wire        restart  = SYS_RST_I | soft_rst;
	wire        summary  = flag_reg[`BIT_PROJECT] | flag_reg[`BIT_SETTINGS] |
		flag_reg[`BIT_SYSFILE];

	// Plain flip-flops only, nothing is ever copied to nonvolatile storage
	assign STATUS_O = {16'h0000, 4'h0, flag_reg[11:6], 1'b0,
		flag_reg[4:3], summary, flag_reg[1:0]};
	assign MOTOR_EN_O = MOTOR_EN_REQ_I & ~flag_reg[`BIT_NOCLK];

	////////////////////////////////////////////////////////////////
	// Start-up checks run one cycle after any reset, hardware or command
	always @(posedge MCLK_I) begin
		if (SYS_RST_I)
			start_reg <= 1'b1;
		else
			start_reg <= soft_rst;
	end

	clock_presence #(.WAIT(CLK_WAIT)) u_phase (
		.clk_i     (MCLK_I),
		.rst_i     (restart),
		.start_i   (start_reg),
		.tick_i    (PHASE_TICK_I),
		.missing_o (ph_miss),
		.done_o    (ph_done)
	);
	clock_presence #(.WAIT(CLK_WAIT)) u_servo (
		.clk_i     (MCLK_I),
		.rst_i     (restart),
		.start_i   (start_reg),
		.tick_i    (SERVO_TICK_I),
		.missing_o (sv_miss),
		.done_o    ()
	);

	////////////////////////////////////////////////////////////////
	// Flags are sticky; only reset or the reset command clears them, except bit 11, which a new save re-evaluates
	always @(posedge MCLK_I) begin
		if (restart) begin
			flag_reg   <= 12'h000;
			BUF_SIZE_O <= BUF_DEFAULT;
			SAVE_GO_O  <= 1'b0;
			// A command reset must not swallow an event or a save of the same cycle
			if (~SYS_RST_I) begin
				flag_reg[`BIT_STOROVF]  <= SAVE_REQ_I & PROGRAM_TOO_BIG_I;
				SAVE_GO_O               <= SAVE_REQ_I & ~PROGRAM_TOO_BIG_I;
				flag_reg[`BIT_STOP]     <= GLOBAL_STOP_I;
				flag_reg[`BIT_SYSFILE]  <= SYSFILE_ERR_I;
				flag_reg[`BIT_SETTINGS] <= SETTINGS_ERR_I;
				flag_reg[`BIT_PROJECT]  <= PROJECT_ERR_I;
				flag_reg[`BIT_RT_WDT]   <= RT_WDT_EXPIRE_I;
				flag_reg[`BIT_BG_WDT]   <= BG_WDT_EXPIRE_I;
			end
		end else begin
			SAVE_GO_O <= 1'b0;
			if (start_reg) begin
				if (BUF_REQ_SIZE_I > RAM_CAPACITY) begin
					flag_reg[`BIT_BUFOVF] <= 1'b1;
					BUF_SIZE_O <= BUF_DEFAULT;
				end else begin
					BUF_SIZE_O <= BUF_REQ_SIZE_I;
				end
				if (FACTORY_DEFAULT_I)
					flag_reg[`BIT_DEFAULT] <= 1'b1;
			end
			// A new save re-evaluates the size, so a smaller program clears it
			if (SAVE_REQ_I) begin
				flag_reg[`BIT_STOROVF] <= PROGRAM_TOO_BIG_I;
				SAVE_GO_O <= ~PROGRAM_TOO_BIG_I;
			end
			if (GLOBAL_STOP_I)
				flag_reg[`BIT_STOP] <= 1'b1;
			if (ph_done & (ph_miss | sv_miss))
				flag_reg[`BIT_NOCLK] <= 1'b1;
			if (SYSFILE_ERR_I)
				flag_reg[`BIT_SYSFILE] <= 1'b1;
			if (SETTINGS_ERR_I)
				flag_reg[`BIT_SETTINGS] <= 1'b1;
			if (PROJECT_ERR_I)
				flag_reg[`BIT_PROJECT] <= 1'b1;
			if (RT_WDT_EXPIRE_I)
				flag_reg[`BIT_RT_WDT] <= 1'b1;
			if (BG_WDT_EXPIRE_I)
				flag_reg[`BIT_BG_WDT] <= 1'b1;
		end
	end

	apb_regs u_bus (
		.clk_i      (MCLK_I),
		.rst_i      (SYS_RST_I),
		.psel_i     (PSEL_I),
		.penable_i  (PENABLE_I),
		.pwrite_i   (PWRITE_I),
		.paddr_i    (PADDR_I),
		.pwdata_i   (PWDATA_I),
		.status_i   (STATUS_O),
		.bufsize_i  (BUF_SIZE_O),
		.pready_o   (PREADY_O),
		.pslverr_o  (PSLVERR_O),
		.prdata_o   (PRDATA_O),
		.ctl_wr_o   (ctl_wr),
		.ctl_data_o (ctl_data)
	);
endmodule

// ===== rtl/fault_word_defs.vh
// How it works
// - One 32-bit word, bits 12-31 undefined zero.
// - Word kept only in volatile flip-flops.
// - Extension swap and setup field read zero.
// - Hardware swap flag bit 5 reads zero.
// - Oversize save sets bit 11, drops save.
// - Each new save re-evaluates storage overflow.
// - At start-up oversize buffer sets bit 10.
// - Buffer overflow substitutes default buffer size.
// - Flags other than bit 11 sticky until power cycle or reset.
// - Global stop sets bit 9, stays set.
// - Missing phase or servo clock in start-up window sets bit 8.
// - System file load error sets bit 6.
// - Faulty saved settings set bit 4.
// - Project file read failure sets bit 3.
// - Bit 2 is OR of bits 3-6.
// - Real-time task watchdog expiry sets bit 1.
// - Background watchdog expiry sets bit 0.
// - Missing clock flag forbids motor enable.
`ifndef FAULT_WORD_DEFS_VH
`define FAULT_WORD_DEFS_VH
`define STATUS_ADDR      12'h000
`define CONTROL_ADDR     12'h004
`define BUFSIZE_ADDR     12'h008
`define BIT_BG_WDT       0
`define BIT_RT_WDT       1
`define BIT_STARTUP      2
`define BIT_PROJECT      3
`define BIT_SETTINGS     4
`define BIT_HW_SWAP      5
`define BIT_SYSFILE      6
`define BIT_DEFAULT      7
`define BIT_NOCLK        8
`define BIT_STOP         9
`define BIT_BUFOVF       10
`define BIT_STOROVF      11
`define CLK_WAIT_CYCLES  16'h0fa0
`endif

// ===== rtl/clock_presence.v
`include "fault_word_defs.vh"
module clock_presence #(
	parameter WAIT = `CLK_WAIT_CYCLES
) (
	input  wire clk_i,
	input  wire rst_i,
	input  wire start_i,
	input  wire tick_i,
	output reg  missing_o,
	output reg  done_o
);
	reg [15:0] cnt_reg;
	reg        seen_reg;
	reg        busy_reg;
	// A window after each start; no tick within it means the clock is missing
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg   <= 16'h0000;
			seen_reg  <= 1'b0;
			busy_reg  <= 1'b0;
			missing_o <= 1'b0;
			done_o    <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				cnt_reg  <= WAIT;
				seen_reg <= 1'b0;
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (tick_i)
					seen_reg <= 1'b1;
				if (cnt_reg == 16'h0000) begin
					busy_reg  <= 1'b0;
					done_o    <= 1'b1;
					missing_o <= ~(seen_reg | tick_i);
				end else begin
					cnt_reg <= cnt_reg - 16'h0001;
				end
			end
		end
	end
endmodule

// ===== rtl/apb_regs.v
`include "fault_word_defs.vh"
module apb_regs (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	input  wire [31:0] status_i,
	input  wire [15:0] bufsize_i,
	output wire        pready_o,
	output wire        pslverr_o,
	output reg  [31:0] prdata_o,
	output reg         ctl_wr_o,
	output reg  [31:0] ctl_data_o
);
	wire acc = psel_i & penable_i;
	wire hit = (paddr_i == `STATUS_ADDR) | (paddr_i == `CONTROL_ADDR) |
		(paddr_i == `BUFSIZE_ADDR);
	assign pready_o  = 1'b1;
	assign pslverr_o = acc & ~hit;
	always @(posedge clk_i) begin
		if (rst_i) begin
			prdata_o   <= 32'h00000000;
			ctl_wr_o   <= 1'b0;
			ctl_data_o <= 32'h00000000;
		end else begin
			ctl_wr_o <= acc & pwrite_i & (paddr_i == `CONTROL_ADDR);
			if (acc & pwrite_i)
				ctl_data_o <= pwdata_i;
			// Status writes are simply dropped
			if (psel_i & ~penable_i & ~pwrite_i) begin
				case (paddr_i)
					`STATUS_ADDR:  prdata_o <= status_i;
					`BUFSIZE_ADDR: prdata_o <= {16'h0000, bufsize_i};
					default:       prdata_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// ===== test/system_fault_status_word_asserts.sv
module system_fault_status_word_asserts (
	input logic        MCLK_I,
	input logic        SYS_RST_I,
	input logic        PSEL_I,
	input logic        PENABLE_I,
	input logic        PWRITE_I,
	input logic [11:0] PADDR_I,
	input logic [31:0] PWDATA_I,
	input logic        SAVE_REQ_I,
	input logic        PROGRAM_TOO_BIG_I,
	input logic        SAVE_GO_O,
	input logic [15:0] BUF_SIZE_O,
	input logic        GLOBAL_STOP_I,
	input logic        MOTOR_EN_REQ_I,
	input logic        MOTOR_EN_O,
	input logic [31:0] STATUS_O
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);
	// Reset command write; clears flags two edges later
	wire clr = PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == 12'h004 && PWDATA_I[0];
	a_free_bits: assert property (STATUS_O[31:12] == 0 && !STATUS_O[5])
		else $error("undefined bits set");
	a_summary_or: assert property (STATUS_O[2] == |{STATUS_O[6], STATUS_O[4:3]})
		else $error("summary bit wrong");
	a_motor_block: assert property (MOTOR_EN_O == (MOTOR_EN_REQ_I && !STATUS_O[8]))
		else $error("motor enable wrong");
	a_stop_sets: assert property (GLOBAL_STOP_I |=> STATUS_O[9])
		else $error("stop flag not set");
	a_flag_hold: assert property ($fell(STATUS_O[9]) |-> $past(clr) || $past(clr, 2))
		else $error("flag dropped");
	a_save_drop: assert property (SAVE_REQ_I && PROGRAM_TOO_BIG_I |=>
		STATUS_O[11] && !SAVE_GO_O)
		else $error("oversize save kept");
	a_save_pass: assert property (SAVE_REQ_I && !PROGRAM_TOO_BIG_I |=>
		SAVE_GO_O && !STATUS_O[11])
		else $error("save not passed");
	a_buf_default: assert property (STATUS_O[10] |-> BUF_SIZE_O == 16'h1000)
		else $error("buffer size kept");
	c_drop: cover property (SAVE_REQ_I && PROGRAM_TOO_BIG_I);
	c_noclk: cover property ($rose(STATUS_O[8]));
	c_clear: cover property (clr);
endmodule

// ===== test/system_fault_status_word_tb.sv
module system_fault_status_word_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic MCLK_I = 0, SYS_RST_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, ticking = 0;
	logic SAVE_REQ_I = 0, PROGRAM_TOO_BIG_I = 0, GLOBAL_STOP_I = 0, PHASE_TICK_I = 0;
	logic SERVO_TICK_I = 0, SYSFILE_ERR_I = 0, SETTINGS_ERR_I = 0, PROJECT_ERR_I = 0;
	logic FACTORY_DEFAULT_I = 1, RT_WDT_EXPIRE_I = 0, BG_WDT_EXPIRE_I = 0, MOTOR_EN_REQ_I = 1;
	logic PREADY_O, PSLVERR_O, SAVE_GO_O, MOTOR_EN_O, err, go_exp = 0;
	logic [11:0] PADDR_I = 0;
	logic [15:0] BUF_REQ_SIZE_I = 16'h5000, BUF_SIZE_O;
	logic [31:0] PWDATA_I = 0, PRDATA_O, STATUS_O, rd, r, model = 0, x = 32'h4fb9;
	int failures = 0, checks_done = 0;
	always #12.5 MCLK_I = ~MCLK_I;
	// Ticks only after start-up check, so the first window must report missing clocks
	always @(posedge MCLK_I) begin
		PHASE_TICK_I <= ticking && !PHASE_TICK_I;
		SERVO_TICK_I <= ticking && !PHASE_TICK_I;
	end
	system_fault_status_word #(.CLK_WAIT(16'h0010)) i_dut (.*);
	function logic [31:0] fold(logic [31:0] f);
		return f | {29'h0, |{f[6], f[4:3]}, 2'h0};
	endfunction
	function logic [31:0] xorshift(logic [31:0] v);
		logic [31:0] s;
		s = v ^ (v << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task check(logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge MCLK_I);
		PSEL_I <= 1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge MCLK_I);
		PENABLE_I <= 1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge MCLK_I);
		end while (PREADY_O !== 1'b1);
		rd = PRDATA_O;
		err = PSLVERR_O;
		PSEL_I <= 0;
		PENABLE_I <= 0;
	endtask
	task end_sim;
		$display("failures %0d checks %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#200us;
		failures++;
		end_sim;
	end
	initial begin
		repeat (5) @(posedge MCLK_I);
		SYS_RST_I <= 0;
		repeat (30) @(posedge MCLK_I);
		check(STATUS_O, 32'h0580);
		check(BUF_SIZE_O, 16'h1000);
		check(MOTOR_EN_O, 0);
		ticking <= 1;
		FACTORY_DEFAULT_I <= 0;
		BUF_REQ_SIZE_I <= 16'h0800;
		apb(1, 12'h004, 1);
		repeat (30) @(posedge MCLK_I);
		check(STATUS_O, 0);
		check(BUF_SIZE_O, 16'h0800);
		check(MOTOR_EN_O, 1);
		apb(0, 12'h008, 0);
		check(rd, 32'h00000800);
		apb(1, 12'h000, '1);
		apb(0, 12'h000, 0);
		check(rd, 0);
		apb(0, 12'h010, 0);
		check(rd, 0);
		check(err, 1);
		for (int i = 0; i <= 300; i++) begin
			@(posedge MCLK_I);
			check(STATUS_O, fold(model));
			check(SAVE_GO_O, go_exp);
			go_exp = SAVE_REQ_I & !PROGRAM_TOO_BIG_I;
			if (SAVE_REQ_I)
				model[11] = PROGRAM_TOO_BIG_I;
			model |= {22'h0, GLOBAL_STOP_I, 2'h0, SYSFILE_ERR_I, 1'b0, SETTINGS_ERR_I,
				PROJECT_ERR_I, 1'b0, RT_WDT_EXPIRE_I, BG_WDT_EXPIRE_I};
			x = xorshift(x);
			r = i < 300 ? x : 0;
			{GLOBAL_STOP_I, SYSFILE_ERR_I, SETTINGS_ERR_I, PROJECT_ERR_I, RT_WDT_EXPIRE_I,
				BG_WDT_EXPIRE_I} <= r[5:0] & r[11:6] & r[17:12] & r[23:18];
			SAVE_REQ_I <= r[24] & r[25] & !SAVE_REQ_I;
			PROGRAM_TOO_BIG_I <= r[26];
			MOTOR_EN_REQ_I <= r[27];
		end
		@(posedge MCLK_I);
		check(STATUS_O, fold(model));
		apb(0, 12'h000, 0);
		check(rd, fold(model));
		// A control write without the reset bit must leave the flags alone
		apb(1, 12'h004, 0);
		repeat (3) @(posedge MCLK_I);
		check(STATUS_O, fold(model));
		apb(1, 12'h004, 1);
		repeat (30) @(posedge MCLK_I);
		check(STATUS_O, 0);
		end_sim;
	end
endmodule
bind system_fault_status_word system_fault_status_word_asserts i_chk (.*);
